// ### llr_map.svh
// offsets, codes, reset values and timing figures of the lock/reset command block
// assumes inclusion by bare name from the lock store, the command core and the testbench
`ifndef LLR_MAP_SVH
`define LLR_MAP_SVH

`define LLR_OP_WR_EN_CMD  8'h06
`define LLR_OP_LOCK_WR    8'he1
`define LLR_OP_LOCK_RD    8'he0
`define LLR_OP_NVLOCK_RD  8'he2
`define LLR_OP_RST_EN     8'h66
`define LLR_OP_RST        8'h99
`define LLR_OP_PARAM      8'h5a
`define LLR_LOCK_SET      8'hff
`define LLR_LOCK_CLR      8'h00
`define LLR_ERASED_BYTE   8'hff
`define LLR_STATUS_RST    16'h0200
`define LLR_LATCH_POS     1
`define LLR_BUSY_POS      0
`define LLR_OP_IDX        4'h1
`define LLR_ADDR_LAST_IDX 4'h5
`define LLR_WVL_LAST_IDX  4'h6
`define LLR_REGION_MSB    27
`define LLR_REGION_LSB    24
`define LLR_REGIONS       16
`define LLR_CLK_NS        100
`define LLR_PWRUP_MS      1.8
`define LLR_RST_CYCLES    32

`endif

// ### llr_pkg.sv
// types shared by the lock/reset command block
// assumes nothing beyond the map header
package llr_pkg;
    typedef enum logic [1:0] {DEV_POWERUP, DEV_READY, DEV_RECOVER} llr_dev_t;
    typedef enum logic [1:0] {CMD_IDLE, CMD_WVL, CMD_RLOCK, CMD_SKIP} llr_cmd_t;
endpackage : llr_pkg

// ### llr_link_if.sv
// links the serial receiver, the command core and the lock store
// assumes all three run on the same clock
`timescale 1ns/1ps
interface llr_link_if;
    logic        byte_vld;
    logic [7:0]  byte_data;
    logic [3:0]  byte_idx;
    logic [2:0]  bit_cnt;
    logic        cs_rise;
    logic        cs_fall;
    logic        sclk_fall;
    logic        wr_en;
    logic [3:0]  wr_idx;
    logic        wr_prot;
    logic        clr;
    logic [3:0]  rd_idx;
    logic        rd_prot;
    logic [15:0] prot_all;

    modport fe_mp (output byte_vld, byte_data, byte_idx, bit_cnt, cs_rise, cs_fall, sclk_fall);
    modport store_mp (input wr_en, wr_idx, wr_prot, clr, rd_idx, output rd_prot, prot_all);
    modport core_mp (input byte_vld, byte_data, byte_idx, bit_cnt, cs_rise, cs_fall, sclk_fall,
                     rd_prot, prot_all, output wr_en, wr_idx, wr_prot, clr, rd_idx);
endinterface : llr_link_if

// ### llr_spi_rx.sv
// serial pin receiver: synchronises pins, finds clock edges, assembles bytes
// assumes the serial clock is far slower than i_clk
`timescale 1ns/1ps
module llr_spi_rx (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_sclk,
    input  wire logic i_cs_n,
    input  wire logic i_si,
    llr_link_if.fe_mp lnk
);
    localparam logic [2:0] FLT_RST = 3'h2;

    logic [2:0] pin;
    logic [2:0] s1_q;
    logic [2:0] s2_q;
    logic [2:0] s3_q;
    logic [2:0] flt_q;
    logic       sclk_prev_q;
    logic       cs_prev_q;
    logic [7:0] sh_q;
    logic [2:0] bit_q;
    logic [3:0] idx_q;
    logic       vld_q;
    logic [7:0] byte_q;

    assign pin = {i_sclk, i_cs_n, i_si};

    ////////////////////////////////////////////////////////////////////////////////
    // a pin change counts only once stages two and three agree
    generate
        for (genvar g = 0; g < 3; g++)
        begin : g_sync
            always_ff @(posedge i_clk)
            begin
                if (i_rst)
                begin
                    s1_q[g]  <= FLT_RST[g];
                    s2_q[g]  <= FLT_RST[g];
                    s3_q[g]  <= FLT_RST[g];
                    flt_q[g] <= FLT_RST[g];
                end
                else
                begin
                    s1_q[g] <= pin[g];
                    s2_q[g] <= s1_q[g];
                    s3_q[g] <= s2_q[g];
                    if (s2_q[g] == s3_q[g])
                        flt_q[g] <= s3_q[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            sclk_prev_q <= 1'b0;
            cs_prev_q   <= 1'b1;
        end
        else
        begin
            sclk_prev_q <= flt_q[2];
            cs_prev_q   <= flt_q[1];
        end
    end

    assign lnk.cs_rise   = flt_q[1] & ~cs_prev_q;
    assign lnk.cs_fall   = ~flt_q[1] & cs_prev_q;
    assign lnk.sclk_fall = ~flt_q[2] & sclk_prev_q & ~flt_q[1];

    ////////////////////////////////////////////////////////////////////////////////
    // bits are taken on the rising serial clock edge while selected
    always_ff @(posedge i_clk)
    begin
        if (i_rst || lnk.cs_fall)
        begin
            sh_q   <= 8'h00;
            bit_q  <= 3'h0;
            idx_q  <= 4'h0;
            vld_q  <= 1'b0;
            byte_q <= 8'h00;
        end
        else
        begin
            vld_q <= 1'b0;
            if (flt_q[2] && !sclk_prev_q && !flt_q[1])
            begin
                sh_q  <= {sh_q[6:0], flt_q[0]};
                bit_q <= bit_q + 3'h1;
                if (bit_q == 3'h7)
                begin
                    byte_q <= {sh_q[6:0], flt_q[0]};
                    vld_q  <= 1'b1;
                    if (idx_q != 4'hf)
                        idx_q <= idx_q + 4'h1;
                end
            end
        end
    end

    assign lnk.byte_vld  = vld_q;
    assign lnk.byte_data = byte_q;
    assign lnk.byte_idx  = idx_q;
    assign lnk.bit_cnt   = bit_q;
endmodule : llr_spi_rx

// ### llr_lock_store.sv
// volatile lock bytes, one protect flag per region
// assumes write and clear come from the command core on the same clock
`timescale 1ns/1ps
`include "llr_map.svh"
module llr_lock_store (
    input  wire logic    i_clk,
    input  wire logic    i_rst,
    llr_link_if.store_mp lnk
);
    logic [`LLR_REGIONS-1:0] lock_q;

    // a full byte is either all ones or all zeros, so one flag per region suffices
    generate
        for (genvar g = 0; g < `LLR_REGIONS; g++)
        begin : g_lock
            always_ff @(posedge i_clk)
            begin
                if (i_rst || lnk.clr)
                    lock_q[g] <= 1'b0;
                else if (lnk.wr_en && (lnk.wr_idx == 4'(g)))
                    lock_q[g] <= lnk.wr_prot;
            end
        end
    endgenerate

    assign lnk.rd_prot  = lock_q[lnk.rd_idx];
    assign lnk.prot_all = lock_q;
endmodule : llr_lock_store

// ### llr_core.sv
// command core for lock-byte write/read, software reset and parameter-read opcode
// assumes serial pins arrive unsynchronised; other flash logic uses o_soft_reset
`timescale 1ns/1ps
`include "llr_map.svh"
module llr_core #(
    parameter int unsigned PWRUP_CYCLES = int'($ceil(`LLR_PWRUP_MS * 1.0e6 / `LLR_CLK_NS)),
    parameter int unsigned RST_CYCLES   = `LLR_RST_CYCLES
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_sclk,
    input  wire logic        i_cs_n,
    input  wire logic        i_si,
    input  wire logic        i_write_in_progress_flag,
    input  wire logic [15:0] i_nonvolatile_lock_byte,
    output logic             o_so,
    output logic             o_so_oe,
    output logic             o_ready,
    output logic             o_write_enable_latch,
    output logic [15:0]      o_status,
    output logic [15:0]      o_volatile_lock_byte,
    output logic             o_soft_reset,
    output logic             o_param_read_req,
    output logic [7:0]       o_array_fill_byte
);
    llr_link_if lnk ();

    llr_pkg::llr_dev_t dev_q;
    llr_pkg::llr_cmd_t cmd_q;
    logic [14:0]       cnt_q;
    logic [7:0]        op_q;
    logic [31:0]       addr_q;
    logic [7:0]        data_q;
    logic              rd_nv_q;
    logic              armed_q;
    logic              wel_q;
    logic [15:0]       status_q;
    logic              rd_go_q;
    logic [7:0]        out_sh_q;
    logic              so_q;
    logic              oe_q;
    logic              soft_rst_q;
    logic              param_q;
    logic [7:0]        fill_q;
    logic              op_vld;
    logic              frame_ok8;
    logic              data_ok;
    logic              wvl_go;
    logic              rst_go;

    llr_spi_rx u_rx (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_sclk (i_sclk),
        .i_cs_n (i_cs_n),
        .i_si   (i_si),
        .lnk    (lnk.fe_mp)
    );

    llr_lock_store u_store (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .lnk   (lnk.store_mp)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // device state: power-up wait, ready, reset recovery
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            dev_q <= llr_pkg::DEV_POWERUP;
            cnt_q <= 15'h0000;
        end
        else
        begin
            case (dev_q)
                llr_pkg::DEV_POWERUP:
                begin
                    cnt_q <= cnt_q + 15'h0001;
                    if (cnt_q == 15'(PWRUP_CYCLES - 1))
                    begin
                        dev_q <= llr_pkg::DEV_READY;
                        cnt_q <= 15'h0000;
                    end
                end
                llr_pkg::DEV_READY:
                    if (rst_go)
                        dev_q <= llr_pkg::DEV_RECOVER;
                llr_pkg::DEV_RECOVER:
                begin
                    cnt_q <= cnt_q + 15'h0001;
                    if (cnt_q == 15'(RST_CYCLES - 1))
                    begin
                        dev_q <= llr_pkg::DEV_READY;
                        cnt_q <= 15'h0000;
                    end
                end
                default:
                    dev_q <= llr_pkg::DEV_POWERUP;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // frame decode
    assign op_vld    = lnk.byte_vld && (lnk.byte_idx == `LLR_OP_IDX);
    assign frame_ok8 = (lnk.byte_idx == `LLR_OP_IDX) && (lnk.bit_cnt == 3'h0);
    assign data_ok   = (data_q == `LLR_LOCK_SET) || (data_q == `LLR_LOCK_CLR);
    assign wvl_go    = lnk.cs_rise && (cmd_q == llr_pkg::CMD_WVL) && wel_q
                       && data_ok && (lnk.byte_idx == `LLR_WVL_LAST_IDX)
                       && (lnk.bit_cnt == 3'h0);
    assign rst_go    = lnk.cs_rise && frame_ok8 && armed_q && (op_q == `LLR_OP_RST)
                       && (dev_q == llr_pkg::DEV_READY);

    always_ff @(posedge i_clk)
    begin
        if (i_rst || lnk.cs_fall)
        begin
            cmd_q   <= llr_pkg::CMD_IDLE;
            op_q    <= 8'h00;
            rd_nv_q <= 1'b0;
        end
        else if (op_vld)
        begin
            op_q <= lnk.byte_data;
            if (dev_q != llr_pkg::DEV_READY)
                cmd_q <= llr_pkg::CMD_SKIP;
            else
            begin
                case (lnk.byte_data)
                    `LLR_OP_LOCK_WR:
                        cmd_q <= llr_pkg::CMD_WVL;
                    `LLR_OP_LOCK_RD, `LLR_OP_NVLOCK_RD:
                    begin
                        // busy array: the read is dropped and the output stays off
                        cmd_q   <= i_write_in_progress_flag ? llr_pkg::CMD_SKIP
                                                            : llr_pkg::CMD_RLOCK;
                        rd_nv_q <= (lnk.byte_data == `LLR_OP_NVLOCK_RD);
                    end
                    default:
                        cmd_q <= llr_pkg::CMD_SKIP;
                endcase
            end
        end
    end

    // four address bytes regardless of the address mode
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            addr_q <= 32'h0000_0000;
            data_q <= 8'h00;
        end
        else if (lnk.byte_vld && (lnk.byte_idx > `LLR_OP_IDX))
        begin
            if (lnk.byte_idx <= `LLR_ADDR_LAST_IDX)
                addr_q <= {addr_q[23:0], lnk.byte_data};
            else if (lnk.byte_idx == `LLR_WVL_LAST_IDX)
                data_q <= lnk.byte_data;
        end
    end

    assign lnk.wr_en   = wvl_go;
    assign lnk.wr_idx  = addr_q[`LLR_REGION_MSB:`LLR_REGION_LSB];
    assign lnk.wr_prot = (data_q == `LLR_LOCK_SET);
    assign lnk.clr     = rst_go;
    assign lnk.rd_idx  = addr_q[`LLR_REGION_MSB:`LLR_REGION_LSB];

    ////////////////////////////////////////////////////////////////////////////////
    // write-enable latch, reset arming, status
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            wel_q   <= 1'b0;
            armed_q <= 1'b0;
        end
        else if (rst_go)
        begin
            wel_q   <= 1'b0;
            armed_q <= 1'b0;
        end
        else if (lnk.cs_rise && (dev_q == llr_pkg::DEV_READY))
        begin
            // any other frame breaks the enable/reset pair
            armed_q <= frame_ok8 && (op_q == `LLR_OP_RST_EN);
            if (frame_ok8 && (op_q == `LLR_OP_WR_EN_CMD))
                wel_q <= 1'b1;
            else if (wvl_go)
                wel_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            status_q <= `LLR_STATUS_RST;
        else
        begin
            status_q[`LLR_LATCH_POS] <= wel_q;
            status_q[`LLR_BUSY_POS]  <= i_write_in_progress_flag;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            soft_rst_q <= 1'b0;
            param_q    <= 1'b0;
            fill_q     <= `LLR_ERASED_BYTE;
        end
        else
        begin
            soft_rst_q <= rst_go;
            param_q    <= op_vld && (dev_q == llr_pkg::DEV_READY)
                          && (lnk.byte_data == `LLR_OP_PARAM);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // lock byte output, shifted out msb first on falling serial clock
    always_ff @(posedge i_clk)
    begin
        if (i_rst || lnk.cs_rise || lnk.cs_fall)
        begin
            rd_go_q  <= 1'b0;
            out_sh_q <= 8'h00;
            so_q     <= 1'b0;
            oe_q     <= 1'b0;
        end
        else
        begin
            if (lnk.byte_vld && (lnk.byte_idx == `LLR_ADDR_LAST_IDX)
                && (cmd_q == llr_pkg::CMD_RLOCK))
                rd_go_q <= 1'b1;
            if (rd_go_q && lnk.sclk_fall)
            begin
                rd_go_q  <= 1'b0;
                oe_q     <= 1'b1;
                out_sh_q <= {7'h00, (rd_nv_q ? i_nonvolatile_lock_byte[lnk.rd_idx]
                                             : lnk.rd_prot)} * 8'hff;
                so_q     <= rd_nv_q ? i_nonvolatile_lock_byte[lnk.rd_idx] : lnk.rd_prot;
            end
            else if (oe_q && lnk.sclk_fall)
            begin
                // all bits of a lock byte are equal, so repeating it needs no reload
                so_q <= out_sh_q[6];
                out_sh_q <= {out_sh_q[6:0], out_sh_q[7]};
            end
        end
    end

    assign o_so                 = so_q;
    assign o_so_oe              = oe_q;
    assign o_ready              = (dev_q == llr_pkg::DEV_READY);
    assign o_write_enable_latch = wel_q;
    assign o_status             = status_q;
    assign o_volatile_lock_byte = lnk.prot_all;
    assign o_soft_reset         = soft_rst_q;
    assign o_param_read_req     = param_q;
    assign o_array_fill_byte    = fill_q;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    property p_bad_data;
        lnk.cs_rise && (cmd_q == llr_pkg::CMD_WVL) && !data_ok |-> !lnk.wr_en;
    endproperty
    a_bad_data: assert property (p_bad_data) else $error("bad lock data written");

    property p_lock_val;
        lnk.wr_en |=> o_volatile_lock_byte[$past(lnk.wr_idx)] == $past(lnk.wr_prot);
    endproperty
    a_lock_val: assert property (p_lock_val) else $error("lock value not stored");

    property p_wvl_now;
        lnk.cs_rise && (cmd_q == llr_pkg::CMD_WVL) && wel_q && data_ok
            && (lnk.byte_idx == 4'h6) && (lnk.bit_cnt == 3'h0) |-> lnk.wr_en;
    endproperty
    a_wvl_now: assert property (p_wvl_now) else $error("lock write delayed");

    property p_wel_clr;
        lnk.wr_en |=> !o_write_enable_latch ##1 !o_status[1];
    endproperty
    a_wel_clr: assert property (p_wel_clr) else $error("latch kept after lock write");

    property p_one_byte;
        lnk.wr_en |-> (lnk.byte_idx == 4'h6) && (lnk.bit_cnt == 3'h0) && $past(wel_q);
    endproperty
    a_one_byte: assert property (p_one_byte) else $error("lock write framing wrong");

    property p_rd_out;
        rd_go_q && lnk.sclk_fall && !lnk.cs_rise |=> o_so_oe;
    endproperty
    a_rd_out: assert property (p_rd_out) else $error("lock byte not driven");

    property p_rd_busy;
        op_vld && i_write_in_progress_flag && (lnk.byte_data == 8'he0) |=> !o_so_oe [*4];
    endproperty
    a_rd_busy: assert property (p_rd_busy) else $error("read served while busy");

    property p_reset;
        o_soft_reset |-> !o_write_enable_latch && (o_volatile_lock_byte == 16'h0000)
                         && !o_ready;
    endproperty
    a_reset: assert property (p_reset) else $error("reset left volatile state");

    property p_recover;
        (dev_q == llr_pkg::DEV_RECOVER) |-> !lnk.wr_en && !rst_go && !o_param_read_req;
    endproperty
    a_recover: assert property (p_recover) else $error("command taken in recovery");

    property p_status_rst;
        $past(i_rst) |-> (o_status == 16'h0200) && (o_array_fill_byte == 8'hff);
    endproperty
    a_status_rst: assert property (p_status_rst) else $error("delivery state wrong");

    property p_param;
        op_vld && o_ready && (lnk.byte_data == 8'h5a) |=> o_param_read_req;
    endproperty
    a_param: assert property (p_param) else $error("parameter read missed");

    c_write: cover property (lnk.wr_en && lnk.wr_prot);
    c_read: cover property (rd_go_q && lnk.sclk_fall);
    c_reset: cover property (o_soft_reset);
    c_latch: cover property ($rose(o_write_enable_latch));
endmodule : llr_core

// ### llr_host_model.sv
// host controller model driving the serial pins of the lock/reset command block
// assumes i_clk is the 10 MHz device clock; the serial clock runs at 800 ns, mode 0
`timescale 1ns/1ps
module llr_host_model (
    input  wire logic i_clk,
    input  wire logic i_so,
    input  wire logic i_so_oe,
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_si
);
    logic [7:0] rd_byte;
    logic       oe_seen;

    initial
    begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_si   = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one frame: n bits msb first, then nrd bits clocked in from the device
    task automatic frame(input logic [63:0] bits, input int n, input int nrd);
        int i;
        oe_seen = 1'b0;
        rd_byte = 8'h00;
        @(negedge i_clk) o_cs_n = 1'b0;
        repeat (4) @(negedge i_clk);
        for (i = 0; i < n + nrd; i++)
        begin
            o_sclk = 1'b0;
            o_si   = (i < n) ? bits[63 - i] : 1'b0;
            repeat (4) @(negedge i_clk);
            o_sclk = 1'b1;
            repeat (4) @(negedge i_clk);
            // sampled late in the high phase, where the device output has settled
            if (i >= n)
                rd_byte = {rd_byte[6:0], i_so};
            oe_seen = oe_seen | (i_so_oe === 1'b1);
        end
        o_sclk = 1'b0;
        repeat (4) @(negedge i_clk);
        o_cs_n = 1'b1;
        // deselected data line must not keep its last value
        o_si   = ~o_si;
        repeat (8) @(negedge i_clk);
    endtask : frame
endmodule : llr_host_model

// ### lock_register_reset_cmds_tb_top.sv
// self-checking bench for the lock/reset command core
// assumes the host model and the map header; power-up wait shortened to 20 cycles
`timescale 1ns/1ps
`include "llr_map.svh"
module lock_register_reset_cmds_tb_top;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        write_in_progress_flag   = 1'b0;
    logic [15:0] nvl   = 16'h0010;
    logic        so, so_oe, ready, write_enable_latch, srst, preq, sclk, cs_n, si;
    logic [15:0] status, vlock, exp_lock;
    logic [7:0]  fill, e;
    int          failures = 0;
    int          n_compared = 0;
    int          cycles = 0;
    int          n_rst = 0;
    int          n_par = 0;
    int          r;
    // the skipped write-enable follows a completed write, so the latch is really clear
    logic [3:0]  t_reg[7] = '{4'h3, 4'h5, 4'h5, 4'hf, 4'h3, 4'h7, 4'h5};
    logic [7:0]  t_dat[7] = '{8'hff, 8'h5a, 8'hff, 8'hff, 8'h00, 8'hff, 8'hfe};
    int          t_n[7]   = '{48, 48, 49, 48, 48, 48, 48};
    logic        t_we[7]  = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};

    always #50 i_clk = ~i_clk;

    llr_core #(.PWRUP_CYCLES(20)) llr_core_inst (
        .i_clk(i_clk), .i_rst(i_rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_si(si),
        .i_write_in_progress_flag(write_in_progress_flag), .i_nonvolatile_lock_byte(nvl), .o_so(so),
        .o_so_oe(so_oe), .o_ready(ready), .o_write_enable_latch(write_enable_latch), .o_status(status),
        .o_volatile_lock_byte(vlock), .o_soft_reset(srst), .o_param_read_req(preq),
        .o_array_fill_byte(fill)
    );

    llr_host_model llr_host_model_inst (
        .i_clk(i_clk), .i_so(so), .i_so_oe(so_oe), .o_sclk(sclk), .o_cs_n(cs_n), .o_si(si)
    );

    // counted on the falling edge, where the registered pulses have settled
    always @(negedge i_clk)
    begin
        n_rst = n_rst + ((srst === 1'b1) ? 1 : 0);
        n_par = n_par + ((preq === 1'b1) ? 1 : 0);
        cycles++;
        if (cycles == 40000)
        begin
            failures++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic cmd(input logic [7:0] op);
        llr_host_model_inst.frame({op, 56'h0}, 8, 0);
    endtask : cmd

    task automatic wait_ready;
        int k;
        for (k = 0; k < 100 && ready !== 1'b1; k++)
            @(negedge i_clk);
        check(16'(ready), 16'h0001);
    endtask : wait_ready

    task automatic rd_lock(input logic [7:0] op, input logic [3:0] rg);
        llr_host_model_inst.frame({op, 4'h9, rg, 24'h00abcd, 24'h0}, 40, 8);
    endtask : rd_lock

    task automatic results;
        if (failures == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (4) @(negedge i_clk);
        i_rst = 1'b0;
        check(status, `LLR_STATUS_RST);
        check(16'(fill), 16'(`LLR_ERASED_BYTE));
        check(16'(ready), 16'h0000);
        wait_ready();
        exp_lock = 16'h0000;
        for (r = 0; r < 7; r++)
        begin
            if (t_we[r])
                cmd(`LLR_OP_WR_EN_CMD);
            llr_host_model_inst.frame({`LLR_OP_LOCK_WR, 4'ha, t_reg[r], 24'h123456, t_dat[r],
                                       16'h0}, t_n[r], 0);
            if (t_we[r] && t_n[r] == 48 && (t_dat[r] == 8'hff || t_dat[r] == 8'h00))
            begin
                exp_lock[t_reg[r]] = t_dat[r][0];
                check(16'(write_enable_latch), 16'h0000);
                check(16'(status[1]), 16'h0000);
            end
            check(vlock, exp_lock);
        end
        cmd(`LLR_OP_WR_EN_CMD);
        check(16'(write_enable_latch), 16'h0001);
        foreach (t_reg[r])
        begin
            rd_lock(`LLR_OP_LOCK_RD, t_reg[r]);
            e = {8{exp_lock[t_reg[r]]}};
            check(16'(llr_host_model_inst.rd_byte), 16'(e));
            rd_lock(`LLR_OP_NVLOCK_RD, r[3:0]);
            e = {8{nvl[r]}};
            check(16'(llr_host_model_inst.rd_byte), 16'(e));
        end
        write_in_progress_flag = 1'b1;
        rd_lock(`LLR_OP_LOCK_RD, 4'h3);
        check(16'(llr_host_model_inst.oe_seen), 16'h0000);
        check(16'(status[0]), 16'h0001);
        write_in_progress_flag = 1'b0;
        cmd(`LLR_OP_PARAM);
        check(16'(n_par), 16'h0001);
        cmd(`LLR_OP_RST_EN);
        cmd(`LLR_OP_WR_EN_CMD);
        cmd(`LLR_OP_RST);
        check(vlock, exp_lock);
        check(16'(status[0]), 16'h0000);
        cmd(`LLR_OP_RST_EN);
        cmd(`LLR_OP_RST);
        check(16'(ready), 16'h0000);
        check(vlock, 16'h0000);
        check(16'(write_enable_latch), 16'h0000);
        check(16'(n_rst), 16'h0001);
        wait_ready();
        check(status, `LLR_STATUS_RST);
        results();
    end
endmodule : lock_register_reset_cmds_tb_top
